/* modulation_config_params.svh */
// modulation_config_params.svh
// offsets, field positions and reset values of the modulation configuration bank
// assumes a 32-bit apb with 12-bit byte addresses, registers in the low byte lane
`ifndef MODULATION_CONFIG_PARAMS_SVH
`define MODULATION_CONFIG_PARAMS_SVH

// ---------------------------------------------------------------
// register indices and byte addresses (address = index * 4)
// ---------------------------------------------------------------
`define AUX_MOD_IDX 8'h28
`define PTM_IDX 8'h29
`define AUX_MOD_ADDR {2'b00, `AUX_MOD_IDX, 2'b00}
`define PTM_ADDR {2'b00, `PTM_IDX, 2'b00}

// ---------------------------------------------------------------
// reset values and write masks
// ---------------------------------------------------------------
`define AUX_MOD_RESET 8'h10
`define PTM_RESET 8'h70
`define AUX_MOD_WMASK 8'hFC

// ---------------------------------------------------------------
// field positions of the auxiliary modulation register
// ---------------------------------------------------------------
`define REG_AM_OFF_BIT 7
`define EXT_POL_BIT 6
`define EXT_EN_BIT 5
`define DRV_LM_BIT 4
`define RESISTIVE_BIT 3
`define SHAPED_BIT 2

// ---------------------------------------------------------------
// field positions of the passive target modulation register
// ---------------------------------------------------------------
`define PTM_MOD_HI 7
`define PTM_MOD_LO 4
`define PTM_UNMOD_HI 3
`define PTM_UNMOD_LO 0

// ---------------------------------------------------------------
// code values
// ---------------------------------------------------------------
`define DRIVE_CODE_HIZ 4'hF
`define AM_INDEX_MAX 4'hF
`define AM_DEPTH_MAX_PCT 7'h52

`endif

/* modulation_config_pkg.sv */
// modulation_config_pkg.sv
// types shared by the modulation configuration bank
// assumes nothing beyond a systemverilog compiler
package modulation_config_pkg;

    // whole state of the bank, registered as one word
    typedef struct packed {
        logic [7:0] aux;          // auxiliary modulation setting
        logic [7:0] ptm;          // passive target modulation
        logic pready;             // apb ready
        logic pslverr;            // apb error
        logic [31:0] prdata;      // apb read data
        logic [3:0] am_code;      // regulator am index in use
        logic [6:0] am_pct;       // regulator am depth in percent
        logic shaped;             // shaped regulator am control
        logic res_en;             // resistive am enabled
        logic [6:0] res_code;     // resistive am modulated resistance
        logic lm_drv_en;          // driver load modulation enabled
        logic [3:0] lm_code;      // driver resistance code in use
        logic [11:0] mod_res;     // modulated state resistance, tenths
        logic mod_hiz;            // modulated state high impedance
        logic [11:0] unmod_res;   // unmodulated state resistance, tenths
        logic unmod_hiz;          // unmodulated state high impedance
        logic lm_pin;             // external load modulation pin level
    } bank_state_type;

endpackage

/* drive_code_decoder.sv */
// drive_code_decoder.sv
// maps a four-bit driver resistance code to a normalized resistance
// assumes the caller registers the result; purely combinational
`timescale 1ns/10ps
`default_nettype none
`include "modulation_config_params.svh"

module drive_code_decoder
(
    // code in
    input wire logic [3:0] code,
    // decoded resistance
    output logic [11:0] resistance_tenths,
    output logic high_z
);

    // -----------------------------------------------------------
    // lookup
    // -----------------------------------------------------------

    // normalized resistance times ten, rising with the code from 0 to 14
    function automatic logic [11:0] res_lookup(input logic [3:0] c);
        logic [11:0] r;
        r = 12'h000;
        unique case (c)
            4'h0: r = 12'h00A;   // 1.0
            4'h1: r = 12'h014;   // 2.0
            4'h2: r = 12'h029;   // 4.1
            4'h3: r = 12'h053;   // 8.3
            4'h4: r = 12'h07A;   // 12.2
            4'h5: r = 12'h0AB;   // 17.1
            4'h6: r = 12'h100;   // 25.6
            4'h7: r = 12'h140;   // 32.0
            4'h8: r = 12'h16E;   // 36.6
            4'h9: r = 12'h1AB;   // 42.7
            4'hA: r = 12'h200;   // 51.2
            4'hB: r = 12'h280;   // 64.0
            4'hC: r = 12'h355;   // 85.3
            4'hD: r = 12'h500;   // 128.0
            4'hE: r = 12'hA00;   // 256.0
            4'hF: r = 12'h000;   // driver floats, no resistance
        endcase
        return r;
    endfunction

    // resistance and float flag
    always_comb
    begin
        resistance_tenths = res_lookup(code);
        high_z = (code == `DRIVE_CODE_HIZ);
    end

endmodule // drive_code_decoder
`default_nettype wire

/* modulation_config_regs.sv */
// modulation_config_regs.sv
// modulation configuration bank of an rf reader front end, apb slave
// assumes amplitude index, resistive code and load modulation come from same-clock logic
//
// Chosen here: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "modulation_config_params.svh"

module modulation_config_regs
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // modulation sources from the transmitter
    input wire logic [3:0] amplitude_mod_index,
    input wire logic [6:0] modulated_drive_resistance,
    input wire logic load_mod_active,
    // regulator am
    output logic [3:0] regulator_am_index,
    output logic [6:0] regulator_am_depth_pct,
    output logic shaped_regulator_mod_ctl,
    // resistive am
    output logic resistive_amplitude_mod_en,
    output logic [6:0] resistive_mod_resistance,
    // driver load modulation
    output logic driver_load_mod_en,
    output logic [3:0] driver_load_code,
    output logic [11:0] modulated_res_tenths,
    output logic modulated_high_z,
    output logic [11:0] unmodulated_res_tenths,
    output logic unmodulated_high_z,
    // external load modulation
    output logic load_mod_output_pin
);

    // -----------------------------------------------------------
    // state
    // -----------------------------------------------------------

    modulation_config_pkg::bank_state_type s_q; // registered state
    modulation_config_pkg::bank_state_type s_d; // next state
    logic [11:0] dec_res [2];   // decoded resistances, modulated then unmodulated
    logic dec_hiz [2];          // decoded float flags
    logic [3:0] dec_code [2];   // codes fed to the decoders

    // -----------------------------------------------------------
    // functions
    // -----------------------------------------------------------

    // address decode: bit 0 auxiliary, bit 1 passive target
    function automatic logic [1:0] reg_sel(input logic [11:0] a);
        return {a == `PTM_ADDR, a == `AUX_MOD_ADDR};
    endfunction

    // modulation depth in percent for an amplitude index
    function automatic logic [6:0] depth_pct(input logic [3:0] i);
        logic [6:0] p;
        p = 7'h00;
        unique case (i)
            4'h0: p = 7'h00;
            4'h1: p = 7'h08;
            4'h2: p = 7'h0A;
            4'h3: p = 7'h0B;
            4'h4: p = 7'h0C;
            4'h5: p = 7'h0D;
            4'h6: p = 7'h0E;
            4'h7: p = 7'h0F;
            4'h8: p = 7'h14;
            4'h9: p = 7'h19;
            4'hA: p = 7'h1E;
            4'hB: p = 7'h28;
            4'hC: p = 7'h32;
            4'hD: p = 7'h3C;
            4'hE: p = 7'h46;
            4'hF: p = 7'h52;
        endcase
        return p;
    endfunction

    // -----------------------------------------------------------
    // resistance decoders
    // -----------------------------------------------------------

    // both nibbles share one table
    assign dec_code[0] = s_q.ptm[`PTM_MOD_HI:`PTM_MOD_LO];
    assign dec_code[1] = s_q.ptm[`PTM_UNMOD_HI:`PTM_UNMOD_LO];

    generate
        for (genvar g = 0; g < 2; g++)
        begin : g_dec
            drive_code_decoder u_dec
            (
                .code(dec_code[g]),
                .resistance_tenths(dec_res[g]),
                .high_z(dec_hiz[g])
            );
        end
    endgenerate

    // -----------------------------------------------------------
    // next state
    // -----------------------------------------------------------

    // apb answers one cycle into the access phase; writes land on the ready edge
    always_comb
    begin
        logic [1:0] sel;
        logic access;
        sel = reg_sel(paddr);
        access = psel && penable;
        s_d = s_q;
        // apb answer
        if (access && !s_q.pready)
        begin
            s_d.pready = 1'b1;
            s_d.pslverr = (sel == 2'b00);
            // reserved bits already held at zero
            s_d.prdata = {24'h000000, (sel[0] ? s_q.aux : 8'h00) | (sel[1] ? s_q.ptm : 8'h00)};
        end
        else
        begin
            s_d.pready = 1'b0;
            s_d.pslverr = 1'b0;
            s_d.prdata = 32'h00000000;
        end
        // write commit on the completing edge, low lane only
        if (access && s_q.pready && pwrite && pstrb[0])
        begin
            if (sel[0])
            begin
                s_d.aux = pwdata[7:0] & `AUX_MOD_WMASK;
            end
            if (sel[1])
            begin
                s_d.ptm = pwdata[7:0];
            end
        end
        // regulator am: inverted enable, index passed through only when on
        s_d.am_code = s_q.aux[`REG_AM_OFF_BIT] ? 4'h0 : amplitude_mod_index;
        s_d.am_pct = s_q.aux[`REG_AM_OFF_BIT] ? 7'h00 : depth_pct(amplitude_mod_index);
        s_d.shaped = s_q.aux[`SHAPED_BIT];
        // resistive am code used only while enabled
        s_d.res_en = s_q.aux[`RESISTIVE_BIT];
        s_d.res_code = s_q.aux[`RESISTIVE_BIT] ? modulated_drive_resistance : 7'h00;
        // driver load modulation picks modulated or unmodulated code
        s_d.lm_drv_en = s_q.aux[`DRV_LM_BIT];
        if (s_q.aux[`DRV_LM_BIT])
        begin
            s_d.lm_code = load_mod_active ? dec_code[0] : dec_code[1];
        end
        else
        begin
            s_d.lm_code = `DRIVE_CODE_HIZ;
        end
        s_d.mod_res = dec_res[0];
        s_d.mod_hiz = dec_hiz[0];
        s_d.unmod_res = dec_res[1];
        s_d.unmod_hiz = dec_hiz[1];
        // external pin: polarity applied, then gated
        if (s_q.aux[`EXT_EN_BIT])
        begin
            s_d.lm_pin = load_mod_active ^ s_q.aux[`EXT_POL_BIT];
        end
        else
        begin
            s_d.lm_pin = 1'b0;
        end
    end

    // -----------------------------------------------------------
    // state register
    // -----------------------------------------------------------

    // synchronous reset to documented defaults
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            s_q <= '0;
            s_q.aux <= `AUX_MOD_RESET;
            s_q.ptm <= `PTM_RESET;
            s_q.lm_drv_en <= 1'b1;
            s_q.lm_code <= `DRIVE_CODE_HIZ;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // -----------------------------------------------------------
    // outputs
    // -----------------------------------------------------------

    assign pready = s_q.pready;
    assign prdata = s_q.prdata;
    assign pslverr = s_q.pslverr;
    assign regulator_am_index = s_q.am_code;
    assign regulator_am_depth_pct = s_q.am_pct;
    assign shaped_regulator_mod_ctl = s_q.shaped;
    assign resistive_amplitude_mod_en = s_q.res_en;
    assign resistive_mod_resistance = s_q.res_code;
    assign driver_load_mod_en = s_q.lm_drv_en;
    assign driver_load_code = s_q.lm_code;
    assign modulated_res_tenths = s_q.mod_res;
    assign modulated_high_z = s_q.mod_hiz;
    assign unmodulated_res_tenths = s_q.unmod_res;
    assign unmodulated_high_z = s_q.unmod_hiz;
    assign load_mod_output_pin = s_q.lm_pin;

    // -----------------------------------------------------------
    // checks
    // -----------------------------------------------------------

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // a write completing at a given address
    sequence wr_done(logic [11:0] a);
        psel && penable && pready && pwrite && pstrb[0] && paddr == a;
    endsequence

    // a read completing at a given address
    sequence rd_done(logic [11:0] a);
        psel && penable && pready && !pwrite && paddr == a;
    endsequence

    // driver load modulation on, target in its modulated state
    sequence lm_mod_phase;
        s_q.aux[`DRV_LM_BIT] && load_mod_active;
    endsequence

    // driver load modulation on, target resting in its unmodulated state
    sequence lm_rest_phase;
        s_q.aux[`DRV_LM_BIT] && !load_mod_active;
    endsequence

    // regulator am: inverted enable, index and depth pass only while on
    reg_am_on_a: assert property (!s_q.aux[`REG_AM_OFF_BIT]
        |=> regulator_am_index == $past(amplitude_mod_index))
        else $error("regulator am index not passed while enabled");
    reg_am_off_a: assert property (s_q.aux[`REG_AM_OFF_BIT]
        |=> regulator_am_index == 4'h0 && regulator_am_depth_pct == 7'h00)
        else $error("regulator am active while disabled");
    am_depth_max_a: assert property (!s_q.aux[`REG_AM_OFF_BIT]
        && amplitude_mod_index == `AM_INDEX_MAX |=> regulator_am_depth_pct == `AM_DEPTH_MAX_PCT)
        else $error("top amplitude index not at full depth");
    // external pin: polarity first, then gate
    ext_pin_gate_a: assert property (!s_q.aux[`EXT_EN_BIT] |=> !load_mod_output_pin)
        else $error("external pin driven while disabled");
    ext_pin_pol_a: assert property (s_q.aux[`EXT_EN_BIT]
        |=> load_mod_output_pin == ($past(load_mod_active) ^ $past(s_q.aux[`EXT_POL_BIT])))
        else $error("external pin polarity wrong");
    // driver load code follows the phase of load modulation
    drv_lm_code_a: assert property (lm_mod_phase
        |=> driver_load_code == $past(s_q.ptm[`PTM_MOD_HI:`PTM_MOD_LO]))
        else $error("driver load code not modulated nibble");
    drv_lm_rest_a: assert property (lm_rest_phase
        |=> driver_load_code == $past(s_q.ptm[`PTM_UNMOD_HI:`PTM_UNMOD_LO]))
        else $error("driver load code not unmodulated nibble");
    drv_lm_off_a: assert property (!s_q.aux[`DRV_LM_BIT]
        |=> driver_load_code == `DRIVE_CODE_HIZ)
        else $error("driver load code used while disabled");
    // resistive am code used only while enabled
    resistive_code_a: assert property (s_q.aux[`RESISTIVE_BIT]
        |=> resistive_mod_resistance == $past(modulated_drive_resistance))
        else $error("resistive am code not used");
    resistive_off_a: assert property (!s_q.aux[`RESISTIVE_BIT]
        |=> resistive_mod_resistance == 7'h00 && !resistive_amplitude_mod_en)
        else $error("resistive am code used while disabled");
    // code fifteen floats the driver in either state
    code_hiz_a: assert property (s_q.ptm[`PTM_UNMOD_HI:`PTM_UNMOD_LO] == `DRIVE_CODE_HIZ
        |=> unmodulated_high_z && unmodulated_res_tenths == 12'h000)
        else $error("code fifteen does not float");
    mod_hiz_a: assert property (s_q.ptm[`PTM_MOD_HI:`PTM_MOD_LO] == `DRIVE_CODE_HIZ
        |=> modulated_high_z && modulated_res_tenths == 12'h000)
        else $error("modulated code fifteen does not float");
    // register writes land on the completing edge, checked one edge later
    ptm_write_a: assert property (wr_done(`PTM_ADDR) |=> s_q.ptm == $past(pwdata[7:0]))
        else $error("passive target write lost");
    aux_write_a: assert property (wr_done(`AUX_MOD_ADDR)
        |=> s_q.aux == ($past(pwdata[7:0]) & `AUX_MOD_WMASK))
        else $error("auxiliary write lost or reserved bits kept");
    reserved_rd_a: assert property (rd_done(`AUX_MOD_ADDR) |-> prdata[1:0] == 2'b00)
        else $error("reserved bits read nonzero");
    apb_answer_a: assert property (psel && penable && !pready |=> pready)
        else $error("apb answer late");

endmodule // modulation_config_regs
`default_nettype wire

/* apb_host_model.sv */
// apb_host_model.sv
// apb master that stands in for host software, one transfer at a time
// assumes callers run in the ref_clk domain and call xfer between edges
`timescale 1ns/10ps
`default_nettype none

module apb_host_model
(
    // clock
    input wire logic ref_clk,
    // apb master side
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb,
    // slave answer
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr
);
    // ----------------------------------------
    // idle bus and one transfer
    // ----------------------------------------
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        pstrb = 4'h0;
    end

    // setup, access held until pready, then release; an edge always passes first
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        input logic [3:0] s, output logic [31:0] r, output logic e);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        // wait for the answer; only the bench watchdog ends a hang
        while (pready !== 1'b1)
        begin
            @(posedge ref_clk);
        end
        r = prdata;
        e = pslverr;
        // released lines carry the inverse so no stale value passes
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= ~w;
        paddr <= ~a;
        pwdata <= ~d;
        pstrb <= ~s;
    endtask
endmodule // apb_host_model
`default_nettype wire

/* modulation_config_regs_bench.sv */
// modulation_config_regs_bench.sv
// self-checking bench of the modulation configuration bank
// assumes apb_host_model and the bank's params header
`timescale 1ns/10ps
`default_nettype none
`include "modulation_config_params.svh"

module modulation_config_regs_bench;
    // bus, stimulus and design outputs
    logic ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, er, load_mod_active;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, outs;
    logic [3:0] pstrb, amplitude_mod_index, regulator_am_index, driver_load_code;
    logic [6:0] modulated_drive_resistance, regulator_am_depth_pct, resistive_mod_resistance;
    logic shaped_regulator_mod_ctl, resistive_amplitude_mod_en, driver_load_mod_en;
    logic [11:0] modulated_res_tenths, unmodulated_res_tenths;
    logic modulated_high_z, unmodulated_high_z, load_mod_output_pin;
    int failures, checked;
    logic [15:0] lfsr;
    logic [7:0] aux, ptm;
    // resistance in tenths and depth in percent by code
    logic [11:0] ten [16] = '{12'h00A, 12'h014, 12'h029, 12'h053, 12'h07A, 12'h0AB,
        12'h100, 12'h140, 12'h16E, 12'h1AB, 12'h200, 12'h280, 12'h355, 12'h500,
        12'hA00, 12'h000};
    logic [6:0] pct [16] = '{7'h00, 7'h08, 7'h0A, 7'h0B, 7'h0C, 7'h0D, 7'h0E, 7'h0F,
        7'h14, 7'h19, 7'h1E, 7'h28, 7'h32, 7'h3C, 7'h46, 7'h52};

    // modulation outputs packed for one compare
    assign outs = {6'h00, regulator_am_index, regulator_am_depth_pct, shaped_regulator_mod_ctl,
        resistive_amplitude_mod_en, resistive_mod_resistance, driver_load_mod_en,
        driver_load_code, load_mod_output_pin};

    // ----------------------------------------
    // instances
    // ----------------------------------------
    modulation_config_regs uut
    (
        .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .amplitude_mod_index(amplitude_mod_index),
        .modulated_drive_resistance(modulated_drive_resistance),
        .load_mod_active(load_mod_active), .regulator_am_index(regulator_am_index),
        .regulator_am_depth_pct(regulator_am_depth_pct),
        .shaped_regulator_mod_ctl(shaped_regulator_mod_ctl),
        .resistive_amplitude_mod_en(resistive_amplitude_mod_en),
        .resistive_mod_resistance(resistive_mod_resistance),
        .driver_load_mod_en(driver_load_mod_en), .driver_load_code(driver_load_code),
        .modulated_res_tenths(modulated_res_tenths), .modulated_high_z(modulated_high_z),
        .unmodulated_res_tenths(unmodulated_res_tenths),
        .unmodulated_high_z(unmodulated_high_z), .load_mod_output_pin(load_mod_output_pin)
    );

    apb_host_model host
    (
        .ref_clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr)
    );

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    // expected modulation outputs from registers and inputs
    function automatic logic [31:0] exp_out(input logic [7:0] a, input logic [7:0] p,
                                           input logic [3:0] i, input logic [6:0] r,
                                           input logic l);
        logic [3:0] dc;
        dc = a[4] ? (l ? p[7:4] : p[3:0]) : 4'hF;
        return {6'h00, a[7] ? 4'h0 : i, a[7] ? 7'h00 : pct[i], a[2], a[3],
                a[3] ? r : 7'h00, a[4], dc, a[5] & (l ^ a[6])};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s);
        host.xfer(1'b1, a, {24'h5A5A5A, d}, s, rd, er);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input logic ee);
        host.xfer(1'b0, a, 32'h00000000, 4'h0, rd, er);
        chk(rd, e);
        chk({31'h0, er}, {31'h0, ee});
    endtask

    task automatic summarize();
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ----------------------------------------
    // clock, watchdog and main sequence
    // ----------------------------------------
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    initial
    begin
        repeat (6000) @(posedge ref_clk);
        failures++;
        summarize();
    end

    initial
    begin
        rst_n = 1'b0;
        amplitude_mod_index = 4'h0;
        modulated_drive_resistance = 7'h00;
        load_mod_active = 1'b0;
        failures = 0;
        checked = 0;
        lfsr = 16'h0040;
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        rd_chk(`AUX_MOD_ADDR, 32'h00000010, 1'b0);
        rd_chk(`PTM_ADDR, 32'h00000070, 1'b0);
        chk(outs, exp_out(8'h10, 8'h70, 4'h0, 7'h00, 1'b0));
        // every drive code in both nibbles, load modulation toggling
        for (int c = 0; c < 16; c++)
        begin
            ptm = {c[3:0], 4'hF - c[3:0]};
            wr(`PTM_ADDR, ptm, 4'h1);
            load_mod_active <= c[0];
            repeat (4) @(posedge ref_clk);
            chk({19'h0, modulated_high_z, modulated_res_tenths}, {19'h0, c == 15, ten[c]});
            chk({19'h0, unmodulated_high_z, unmodulated_res_tenths}, {19'h0, c == 0, ten[15 - c]});
            chk(outs, exp_out(8'h10, ptm, 4'h0, 7'h00, c[0]));
        end
        ptm = 8'h3C;
        wr(`PTM_ADDR, ptm, 4'h1);
        // random control bytes, every amplitude index
        for (int k = 0; k < 48; k++)
        begin
            lfsr = lfsr_next(lfsr);
            aux = lfsr[7:0];
            aux[2] = aux[2] & aux[7];
            wr(`AUX_MOD_ADDR, aux, 4'h1);
            amplitude_mod_index <= k[3:0];
            modulated_drive_resistance <= lfsr[14:8];
            load_mod_active <= lfsr[15];
            rd_chk(`AUX_MOD_ADDR, {24'h0, aux & 8'hFC}, 1'b0);
            repeat (4) @(posedge ref_clk);
            chk(outs, exp_out(aux, ptm, k[3:0], lfsr[14:8], lfsr[15]));
        end
        // unmapped place, masked write, reset in mid-run
        rd_chk(12'h0A8, 32'h00000000, 1'b1);
        wr(12'h0A8, 8'hFF, 4'h1);
        chk({31'h0, er}, 32'h00000001);
        wr(`PTM_ADDR, 8'h5A, 4'h0);
        rd_chk(`PTM_ADDR, {24'h0, ptm}, 1'b0);
        wr(`AUX_MOD_ADDR, 8'hEC, 4'h1);
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd_chk(`AUX_MOD_ADDR, 32'h00000010, 1'b0);
        summarize();
    end
endmodule // modulation_config_regs_bench
`default_nettype wire
